// >>> inc/fsa_pkg.sv
`default_nettype none
package fsa_pkg;
  // Clocking and link timing
  localparam int CLK_NS = 5;
  localparam int LINK_PERIOD_NS = 125;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_NS);
  localparam int TOOL_RESET_NS = 1000;
  localparam int TOOL_RESET_CYC = (TOOL_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int TOOL_GAP_HALVES = 4;
  // Flash organisation
  localparam int FLASH_BYTES = 12288;
  localparam int IDX_W = $clog2(FLASH_BYTES);
  localparam int SECTOR_BYTES = 4096;
  localparam int SECTORS = (FLASH_BYTES <= SECTOR_BYTES) ? 1 :
                           (FLASH_BYTES <= 2 * SECTOR_BYTES) ? 2 : 3;
  localparam logic [15:0] FLASH_BASE = 16'(65536 - FLASH_BYTES);
  localparam logic [15:0] SEC0_BASE = 16'hf000;
  localparam logic [15:0] SEC0_END = 16'hffff;
  localparam logic [15:0] SEC1_BASE = 16'he000;
  localparam logic [15:0] SEC1_END = 16'hefff;
  localparam logic [15:0] SEC2_END = 16'hdfff;
  localparam logic [15:0] VECTOR_BASE = 16'hffe0;
  localparam logic [7:0] ERASED = 8'hff;
  // Register map
  localparam logic [15:0] CTRL_ADDR = 16'h0029;
  localparam logic [15:0] ADDR_LO_ADDR = 16'h002a;
  localparam logic [15:0] ADDR_HI_ADDR = 16'h002b;
  localparam logic [15:0] DATA_ADDR = 16'h002c;
  localparam logic [15:0] STATUS_ADDR = 16'h002d;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int FC_PROG = 0;
  localparam int FC_SERASE = 1;
  localparam int FC_MERASE = 2;
  localparam int FC_REFUSED = 3;
  localparam int FC_BUSY = 4;
  localparam int ST_PROT = 0;
  localparam int ST_LINK = 1;
  localparam int ST_TOOL = 2;
  localparam int ST_DETECT = 3;
  localparam int ST_REFUSED = 4;
  // Link frame: command, address, data byte
  localparam int FRAME_BITS = 32;
  localparam int HDR_BITS = 24;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_SERASE = 8'h03;
  localparam logic [7:0] CMD_MERASE = 8'h04;
  localparam logic [7:0] CMD_OPTION = 8'h05;
  localparam logic [7:0] CMD_STATUS = 8'h06;
endpackage
`default_nettype wire

// >>> inc/fsa_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fsa_link_if;
  logic comm_clk;
  logic tool_data_o;
  logic tool_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic reset_n;
  logic vpp;
  logic present;
  logic data;
  // Shared data line with pull-up
  assign data = tool_data_oe ? tool_data_o : (dev_data_oe ? dev_data_o : 1'b1);
  modport dev (input comm_clk, data, reset_n, vpp, present, output dev_data_o, dev_data_oe);
  modport tool (output comm_clk, tool_data_o, tool_data_oe, reset_n, vpp, present,
                input data);
endinterface
`default_nettype wire

// >>> rtl/fsa_tool.sv
`timescale 1ns/100ps
`default_nettype none
module fsa_tool (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // User side
  input wire logic session,
  input wire logic start,
  input wire logic [7:0] cmd,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic ready,
  output logic [7:0] rdata,
  output logic rdone,
  // Link
  fsa_link_if.tool link
);
  typedef enum logic [2:0] {T_OFF, T_RESET, T_READY, T_SEND, T_GAP} fsa_tstate_t;
  fsa_tstate_t st_q;
  logic [7:0] cnt_q;
  logic [4:0] bit_q;
  logic [31:0] sh_q;
  logic rd_q, clk_q, do_q, oe_q, rstn_q, vpp_q, pres_q, busy_q, rdone_q, ready_q;
  logic [7:0] rdata_q;
  wire half_end = (cnt_q == 8'(fsa_pkg::LINK_HALF_CYC - 1));
  wire is_rd = (cmd == fsa_pkg::CMD_READ) || (cmd == fsa_pkg::CMD_STATUS);
  wire in_reply = rd_q && (bit_q >= 5'(fsa_pkg::HDR_BITS));
  wire next_reply = rd_q && ((bit_q + 5'h01) >= 5'(fsa_pkg::HDR_BITS));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= T_OFF;
      cnt_q <= 8'h00;
      bit_q <= 5'h00;
      sh_q <= 32'h0;
      rd_q <= 1'b0;
      clk_q <= 1'b0;
      do_q <= 1'b1;
      oe_q <= 1'b0;
      rstn_q <= 1'b1;
      vpp_q <= 1'b0;
      pres_q <= 1'b0;
      busy_q <= 1'b0;
      rdone_q <= 1'b0;
      rdata_q <= 8'h00;
      ready_q <= 1'b0;
    end else if (ce) begin
      pres_q <= 1'b1;
      rdone_q <= 1'b0;
      case (st_q)
        T_OFF: begin
          if (session) begin
            rstn_q <= 1'b0;
            vpp_q <= 1'b1;
            cnt_q <= 8'h00;
            st_q <= T_RESET;
          end
        end
        T_RESET: begin
          if (cnt_q == 8'(fsa_pkg::TOOL_RESET_CYC - 1)) begin
            rstn_q <= 1'b1;
            ready_q <= 1'b1;
            st_q <= T_READY;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        T_READY: begin
          if (!session) begin
            vpp_q <= 1'b0;
            ready_q <= 1'b0;
            st_q <= T_OFF;
          end else if (start) begin
            sh_q <= {cmd, addr, wdata};
            rd_q <= is_rd;
            do_q <= cmd[7];
            oe_q <= 1'b1;
            busy_q <= 1'b1;
            ready_q <= 1'b0;
            bit_q <= 5'h00;
            cnt_q <= 8'h00;
            st_q <= T_SEND;
          end
        end
        T_SEND: begin
          cnt_q <= half_end ? 8'h00 : cnt_q + 8'h01;
          if (half_end && !clk_q) begin
            clk_q <= 1'b1;
            if (in_reply) begin
              rdata_q <= {rdata_q[6:0], link.data};
            end
          end else if (half_end) begin
            clk_q <= 1'b0;
            if (bit_q == 5'(fsa_pkg::FRAME_BITS - 1)) begin
              oe_q <= 1'b0;
              st_q <= T_GAP;
            end else begin
              bit_q <= bit_q + 5'h01;
              sh_q <= {sh_q[30:0], 1'b0};
              do_q <= sh_q[30];
              oe_q <= !next_reply;
            end
          end
        end
        T_GAP: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(fsa_pkg::TOOL_GAP_HALVES * fsa_pkg::LINK_HALF_CYC - 1)) begin
            busy_q <= 1'b0;
            rdone_q <= rd_q;
            ready_q <= 1'b1;
            st_q <= T_READY;
          end
        end
        default: begin
          st_q <= T_OFF;
          ready_q <= 1'b0;
        end
      endcase
    end
  end
  assign link.comm_clk = clk_q;
  assign link.tool_data_o = do_q;
  assign link.tool_data_oe = oe_q;
  assign link.reset_n = rstn_q;
  assign link.vpp = vpp_q;
  assign link.present = pres_q;
  assign busy = busy_q;
  assign rdata = rdata_q;
  assign rdone = rdone_q;
  assign ready = ready_q;
endmodule
`default_nettype wire

// >>> rtl/fsa_device.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - One, two or three sectors by size
// - Each sector erases on its own
// - Sectors 0,1 are 4K at top
// - Vectors fetched from sector 0
// - Protection blocks read-out and flash writes
// - Removing protection erases whole array first
// - Protection follows the option bit only
// - Low-voltage detector off while protected
// - Link is serial clock plus data
// - Tool attached frees no link pins
// - Tool drives device reset during session
// - Application gives no reset during session
// - Tool switches device into link mode
// - RAM program picks count, address, interface
// - Application programming runs sector 0 loader
// - Application programming never touches sector 0
// - Control/status register at 0029h resets 00h
// - Whole/sector erase, byte program need supply
// - Link mode may change every sector
module fsa_device (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Application side
  input wire logic detector_request,
  output logic detector_enable,
  output logic app_pins_free,
  output logic link_mode_active,
  output logic readout_protect_option_bit,
  // Link
  fsa_link_if.dev link
);
  localparam int P_CLK = 0;
  localparam int P_DATA = 1;
  localparam int P_RSTN = 2;
  localparam int P_VPP = 3;
  localparam int P_PRES = 4;

  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= fsa_pkg::SEC0_BASE) begin
      return 2'h0;
    end else if (a >= fsa_pkg::SEC1_BASE) begin
      return 2'h1;
    end else begin
      return 2'h2;
    end
  endfunction

  // Pin synchronisers: change accepted when stages 2 and 3 agree
  wire [4:0] pin_raw = {link.present, link.vpp, link.reset_n, link.data, link.comm_clk};
  logic [4:0] s1_q, s2_q, s3_q, filt_q;
  wire [4:0] agree = s2_q ~^ s3_q;
  wire [4:0] filt_d = (agree & s2_q) | (~agree & filt_q);
  wire clk_rise = filt_d[P_CLK] && !filt_q[P_CLK];
  wire clk_fall = !filt_d[P_CLK] && filt_q[P_CLK];
  wire rstn_rise = filt_d[P_RSTN] && !filt_q[P_RSTN];

  logic [7:0] mem [fsa_pkg::FLASH_BYTES];
  logic link_mode_q, protect_q, refused_q, walk_q, unprot_q;
  logic [15:0] walk_ptr_q, walk_end_q, addr_q;
  logic [7:0] data_q, rdata_q, tx_q;
  logic [31:0] sh_q;
  logic [5:0] bit_q;
  logic tx_mode_q, do_q, oe_q, detect_q, free_q;

  // Link receive decode
  wire link_up = link_mode_q && filt_q[P_RSTN];
  wire [31:0] frame = {sh_q[30:0], filt_q[P_DATA]};
  wire hdr_done = link_up && clk_rise && (bit_q == 6'(fsa_pkg::HDR_BITS - 1));
  wire frame_done = link_up && clk_rise && (bit_q == 6'(fsa_pkg::FRAME_BITS - 1));
  wire [7:0] f_cmd = frame[31:24];
  wire [15:0] f_addr = frame[23:8];
  wire [7:0] h_cmd = frame[23:16];
  wire [15:0] h_addr = frame[15:0];
  wire [7:0] status = {3'b000, refused_q, detect_q, filt_q[P_PRES], link_mode_q, protect_q};

  // Flash read paths
  wire h_in = h_addr >= fsa_pkg::FLASH_BASE;
  wire [fsa_pkg::IDX_W-1:0] h_idx = fsa_pkg::IDX_W'(h_addr - fsa_pkg::FLASH_BASE);
  wire [7:0] link_flash = (h_in && !protect_q) ? mem[h_idx] : 8'h00;
  wire [7:0] tx_load = (h_cmd == fsa_pkg::CMD_STATUS) ? status : link_flash;
  wire tx_start = hdr_done && ((h_cmd == fsa_pkg::CMD_READ) || (h_cmd == fsa_pkg::CMD_STATUS));

  // Operation request, link and register port in the same cycle are both refused
  wire link_go = frame_done && (f_cmd >= fsa_pkg::CMD_WRITE) && (f_cmd <= fsa_pkg::CMD_OPTION);
  wire ctrl_hit = (addr == fsa_pkg::CTRL_ADDR);
  wire cpu_go = wr && ctrl_hit && (|wdata[fsa_pkg::FC_MERASE:fsa_pkg::FC_PROG]);
  wire op_go = link_go || cpu_go;
  wire [15:0] op_addr = link_go ? f_addr : addr_q;
  wire [7:0] op_data = link_go ? frame[7:0] : data_q;
  wire k_prog = link_go ? (f_cmd == fsa_pkg::CMD_WRITE) : wdata[fsa_pkg::FC_PROG];
  wire k_serase = link_go ? (f_cmd == fsa_pkg::CMD_SERASE)
                          : (!wdata[fsa_pkg::FC_PROG] && wdata[fsa_pkg::FC_SERASE]);
  wire k_merase = link_go ? (f_cmd == fsa_pkg::CMD_MERASE)
                          : (wdata[fsa_pkg::FC_SERASE:fsa_pkg::FC_PROG] == 2'h0);
  wire k_option = link_go && (f_cmd == fsa_pkg::CMD_OPTION);
  wire [1:0] op_sec = sector_of(op_addr);
  wire op_in = (op_addr >= fsa_pkg::FLASH_BASE) && (op_sec < 2'(fsa_pkg::SECTORS));
  wire app_mode = !link_mode_q;
  wire lock0 = app_mode && (k_merase || ((k_prog || k_serase) && op_sec == 2'h0));
  wire refuse = walk_q || !filt_q[P_VPP]
             || (!k_option && protect_q)
             || ((k_prog || k_serase) && !op_in) || lock0 || (cpu_go && link_go);
  wire ok = op_go && !refuse;
  wire do_prog = ok && k_prog;
  wire clear_prot = ok && k_option && !op_data[0] && protect_q;
  wire start_walk = ok && (k_serase || k_merase) || clear_prot;
  wire [15:0] ws = (k_merase || clear_prot) ? fsa_pkg::FLASH_BASE :
                   (op_sec == 2'h0) ? fsa_pkg::SEC0_BASE :
                   (op_sec == 2'h1) ? fsa_pkg::SEC1_BASE : fsa_pkg::FLASH_BASE;
  wire [15:0] we_end = (k_merase || clear_prot || op_sec == 2'h0) ? fsa_pkg::SEC0_END :
                       (op_sec == 2'h1) ? fsa_pkg::SEC1_END : fsa_pkg::SEC2_END;

  // Single write port into the array
  wire mem_we = walk_q || do_prog;
  wire [15:0] mem_a = walk_q ? walk_ptr_q : op_addr;
  wire [fsa_pkg::IDX_W-1:0] mem_idx = fsa_pkg::IDX_W'(mem_a - fsa_pkg::FLASH_BASE);
  wire [7:0] mem_d = walk_q ? fsa_pkg::ERASED : op_data;

  // Register port read decode
  wire [7:0] ctrl_rd = {3'b000, walk_q, refused_q, 3'b000};
  wire cpu_flash = addr >= fsa_pkg::FLASH_BASE;
  wire [fsa_pkg::IDX_W-1:0] cpu_idx = fsa_pkg::IDX_W'(addr - fsa_pkg::FLASH_BASE);
  wire [7:0] rd_mux = ctrl_hit ? ctrl_rd :
                      (addr == fsa_pkg::ADDR_LO_ADDR) ? addr_q[7:0] :
                      (addr == fsa_pkg::ADDR_HI_ADDR) ? addr_q[15:8] :
                      (addr == fsa_pkg::DATA_ADDR) ? data_q :
                      (addr == fsa_pkg::STATUS_ADDR) ? status :
                      cpu_flash ? mem[cpu_idx] : 8'h00;
  wire clr_ref = wr && ctrl_hit && wdata[fsa_pkg::FC_REFUSED];

  always_ff @(posedge ref_clk) begin
    if (ce && mem_we) begin
      mem[mem_idx] <= mem_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
      filt_q <= 5'h00;
    end else if (ce) begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  // Session state and link shifter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_mode_q <= 1'b0;
      sh_q <= 32'h0;
      bit_q <= 6'h00;
      tx_mode_q <= 1'b0;
      tx_q <= 8'h00;
      do_q <= 1'b1;
      oe_q <= 1'b0;
    end else if (ce) begin
      if (!filt_q[P_VPP] || !filt_q[P_PRES]) begin
        link_mode_q <= 1'b0;
      end else if (rstn_rise) begin
        link_mode_q <= 1'b1;
      end
      if (!link_up) begin
        bit_q <= 6'h00;
        tx_mode_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (frame_done) begin
        bit_q <= 6'h00;
        tx_mode_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (clk_rise) begin
        sh_q <= frame;
        bit_q <= bit_q + 6'h01;
        if (tx_start) begin
          tx_q <= tx_load;
          tx_mode_q <= 1'b1;
        end
      end else if (clk_fall && tx_mode_q) begin
        do_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
        oe_q <= 1'b1;
      end
    end
  end

  // Registers, erase walker and protection option
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_q <= 16'h0000;
      data_q <= 8'h00;
      rdata_q <= fsa_pkg::CTRL_RESET;
      refused_q <= 1'b0;
      protect_q <= 1'b0;
      walk_q <= 1'b0;
      unprot_q <= 1'b0;
      walk_ptr_q <= 16'h0000;
      walk_end_q <= 16'h0000;
      detect_q <= 1'b0;
      free_q <= 1'b1;
    end else if (ce) begin
      if (wr && addr == fsa_pkg::ADDR_LO_ADDR) addr_q[7:0] <= wdata;
      if (wr && addr == fsa_pkg::ADDR_HI_ADDR) addr_q[15:8] <= wdata;
      if (wr && addr == fsa_pkg::DATA_ADDR) data_q <= wdata;
      if (rd) rdata_q <= rd_mux;
      if (op_go && refuse) begin
        refused_q <= 1'b1;
      end else if (clr_ref) begin
        refused_q <= 1'b0;
      end
      if (start_walk) begin
        walk_q <= 1'b1;
        walk_ptr_q <= ws;
        walk_end_q <= we_end;
        unprot_q <= clear_prot;
      end else if (walk_q) begin
        walk_ptr_q <= walk_ptr_q + 16'h0001;
        if (walk_ptr_q == walk_end_q) begin
          walk_q <= 1'b0;
          unprot_q <= 1'b0;
          if (unprot_q) protect_q <= 1'b0;
        end
      end
      if (ok && k_option && op_data[0]) protect_q <= 1'b1;
      detect_q <= detector_request && !protect_q;
      free_q <= !filt_q[P_PRES];
    end
  end

  assign rdata = rdata_q;
  assign detector_enable = detect_q;
  assign app_pins_free = free_q;
  assign link_mode_active = link_mode_q;
  assign readout_protect_option_bit = protect_q;
  assign link.dev_data_o = do_q;
  assign link.dev_data_oe = oe_q;
endmodule
`default_nettype wire

// >>> tb/fsa_link_props.sv
`timescale 1ns/100ps
`default_nettype none
module fsa_link_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link
  input wire logic comm_clk,
  input wire logic tool_data_o,
  input wire logic tool_data_oe,
  input wire logic dev_data_o,
  input wire logic dev_data_oe,
  input wire logic reset_n,
  input wire logic vpp,
  input wire logic present,
  input wire logic data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_one_driver: assert property (!(tool_data_oe && dev_data_oe))
    else $error("both ends drive the data line");
  a_tool_quiet: assert property (!reset_n |-> !tool_data_oe)
    else $error("tool drives data while device held in reset");
  a_dev_level: assert property (dev_data_oe && !tool_data_oe |-> data == dev_data_o)
    else $error("device bit not on the line");
  a_tool_absent: assert property (!present |-> !dev_data_oe)
    else $error("device drives with no tool attached");
  a_enter_reset: assert property ($rose(vpp) |-> !reset_n)
    else $error("supply raised outside reset");
  a_reset_hold: assert property ($fell(reset_n) |-> !reset_n [*8])
    else $error("device reset pulse too short");
  a_quiet_reset: assert property (!reset_n |-> !comm_clk && !dev_data_oe)
    else $error("link active while device held in reset");
  a_clk_high: assert property ($rose(comm_clk) |-> comm_clk [*8])
    else $error("link clock high phase too short");
  a_bit_hold: assert property (comm_clk && $past(comm_clk) && tool_data_oe &&
    $past(tool_data_oe) |-> $stable(tool_data_o))
    else $error("tool bit changed while clock high");
  a_dev_start: assert property ($rose(dev_data_oe) |-> !comm_clk)
    else $error("device started driving with clock high");
endmodule
`default_nettype wire

// >>> tb/tb_flash_sector_protection_access.sv
`timescale 1ns/100ps
`default_nettype none
module tb_flash_sector_protection_access;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = '0;
  logic [7:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic detector_request = 1'b0;
  logic session = 1'b0;
  logic start = 1'b0;
  logic [7:0] cmd = '0;
  logic [15:0] t_addr = '0;
  logic [7:0] t_wdata = '0;
  logic [7:0] rdata, t_rdata, v;
  logic detector_enable, app_pins_free, link_mode, prot_bit, t_busy, t_ready, t_rdone;
  logic [15:0] ta [3];
  logic [7:0] td [3];
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  int rdone_n = 0;
  fsa_link_if link ();
  fsa_device u_fsa_device (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .detector_request(detector_request),
    .detector_enable(detector_enable), .app_pins_free(app_pins_free),
    .link_mode_active(link_mode),
    .readout_protect_option_bit(prot_bit), .link(link.dev));
  fsa_tool u_fsa_tool (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .session(session),
    .start(start), .cmd(cmd), .addr(t_addr), .wdata(t_wdata), .busy(t_busy),
    .ready(t_ready), .rdata(t_rdata), .rdone(t_rdone), .link(link.tool));
  fsa_link_props u_fsa_link_props (.ref_clk(ref_clk), .rst(rst), .comm_clk(link.comm_clk),
    .tool_data_o(link.tool_data_o), .tool_data_oe(link.tool_data_oe),
    .dev_data_o(link.dev_data_o), .dev_data_oe(link.dev_data_oe), .reset_n(link.reset_n),
    .vpp(link.vpp), .present(link.present), .data(link.data));
  always #2.5 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (t_rdone === 1'b1) rdone_n++;
    if (cycles == 90000) begin
      err_total++;
      $display("Timeout after %0d cycles", cycles);
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Control register image: busy in bit 4, refused in bit 3
  function automatic logic [7:0] ctrl_exp(input logic busy, input logic refused);
    return {3'h0, busy, refused, 3'h0};
  endfunction
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Leaves the last control read in v
  task automatic cpu_op(input logic [15:0] a, input logic [7:0] d, input logic [7:0] op);
    int n;
    n = 0;
    wr_reg(fsa_pkg::ADDR_LO_ADDR, a[7:0]);
    wr_reg(fsa_pkg::ADDR_HI_ADDR, a[15:8]);
    wr_reg(fsa_pkg::DATA_ADDR, d);
    wr_reg(16'h0029, op);
    v = 8'h10;
    while (v[4] && n < 20000) begin
      rd_reg(16'h0029, v);
      n++;
    end
    chk(v & 8'h10, 8'h00);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    #1;
    while (!t_ready && n < 5000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk({7'h00, t_ready}, 8'h01);
  endtask
  task automatic tool_op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    wait_ready();
    @(posedge ref_clk);
    start <= 1'b1;
    cmd <= c;
    t_addr <= a;
    t_wdata <= d;
    @(posedge ref_clk);
    start <= 1'b0;
    #1 chk({7'h00, t_busy}, 8'h01);
    wait_ready();
  endtask
  initial begin
    void'($urandom(32'h5bf4499e));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd_reg(16'h0029, v);
    chk(v, ctrl_exp(1'b0, 1'b0));
    rd_reg(16'h0030, v);
    chk(v, 8'h00);
    chk({7'h00, app_pins_free}, 8'h00);
    $display("test reset done");
    @(posedge ref_clk);
    session <= 1'b1;
    wait_ready();
    repeat (8) @(posedge ref_clk);
    chk({7'h00, link_mode}, 8'h01);
    tool_op(fsa_pkg::CMD_MERASE, 16'h0000, 8'h00);
    cpu_op(16'h0000, 8'h00, 8'h00);
    ta[0] = fsa_pkg::VECTOR_BASE;
    ta[1] = fsa_pkg::SEC1_END;
    ta[2] = {4'hd, 11'($urandom), 1'b1};
    for (int s = 0; s < 3; s++) begin
      td[s] = {1'b0, 7'($urandom)};
      rd_reg(ta[s], v);
      chk(v, fsa_pkg::ERASED);
      cpu_op(ta[s], td[s], 8'h01);
      rd_reg(ta[s], v);
      chk(v, td[s]);
      tool_op(fsa_pkg::CMD_READ, ta[s], 8'h00);
      chk(t_rdata, td[s]);
    end
    tool_op(fsa_pkg::CMD_WRITE, 16'hd000, 8'h3c);
    rd_reg(16'hd000, v);
    chk(v, 8'h3c);
    $display("test program done");
    cpu_op(ta[1], 8'h00, 8'h02);
    for (int s = 0; s < 3; s++) begin
      rd_reg(ta[s], v);
      chk(v, (s == 1) ? fsa_pkg::ERASED : td[s]);
    end
    $display("test sector erase done");
    tool_op(fsa_pkg::CMD_OPTION, 16'h0000, 8'h01);
    chk({7'h00, prot_bit}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      detector_request <= 1'($urandom);
      repeat (4) @(posedge ref_clk);
      chk({7'h00, detector_enable}, 8'h00);
    end
    tool_op(fsa_pkg::CMD_READ, ta[0], 8'h00);
    chk(t_rdata, 8'h00);
    tool_op(fsa_pkg::CMD_WRITE, ta[2], 8'h22);
    rd_reg(16'h0029, v);
    chk(v, ctrl_exp(1'b0, 1'b1));
    wr_reg(16'h0029, 8'h08);
    cpu_op(ta[2], 8'h11, 8'h01);
    chk(v, ctrl_exp(1'b0, 1'b1));
    rd_reg(ta[2], v);
    chk(v, td[2]);
    wr_reg(16'h0029, 8'h08);
    @(posedge ref_clk);
    detector_request <= 1'b1;
    tool_op(fsa_pkg::CMD_OPTION, 16'h0000, 8'h00);
    cpu_op(16'h0000, 8'h00, 8'h00);
    chk({7'h00, prot_bit}, 8'h00);
    chk({7'h00, detector_enable}, 8'h01);
    for (int s = 0; s < 3; s++) begin
      rd_reg(ta[s], v);
      chk(v, fsa_pkg::ERASED);
    end
    // Status: detector on, tool present, link mode, unprotected
    tool_op(fsa_pkg::CMD_STATUS, 16'h0000, 8'h00);
    chk(t_rdata, 8'h0e);
    $display("test protection done");
    @(posedge ref_clk);
    session <= 1'b0;
    repeat (8) @(posedge ref_clk);
    cpu_op(fsa_pkg::SEC0_BASE, 8'h00, 8'h01);
    chk(v, ctrl_exp(1'b0, 1'b1));
    rd_reg(fsa_pkg::SEC0_BASE, v);
    chk(v, fsa_pkg::ERASED);
    $display("test application lock done");
    chk(8'(rdone_n), 8'h05);
    stop_test();
  end
endmodule
`default_nettype wire
